// >>> testbench/uic_chk.sv
// Purpose: port checks of the serial control block
// Assumes: baud divisor left at one
// Notes: bound to uic_top
`timescale 1ns/1ps
module uic_chk
    import uic_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [11:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR,
    input wire logic RD,
    input wire logic [7:0] RD_DATA,
    input wire logic RXD,
    input wire logic TXD,
    input wire logic CTS_N,
    input wire logic TX_IRQ,
    input wire logic RX_IRQ
);
    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (RESET);
    // ==========
    // Cycles the transmitter has been gated off
    logic [7:0] ctl0_ff;
    logic [9:0] off_cnt_ff;
    logic tx_off;
    assign tx_off = !ctl0_ff[UIC_C0_TX_ENABLE] || (ctl0_ff[UIC_C0_FLOW_CONTROL_ENABLE] && CTS_N);
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctl0_ff <= 8'h00;
        end else if (WR && ADDR == UIC_ADDR_CTL0) begin
            ctl0_ff <= WR_DATA;
        end
    end
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            off_cnt_ff <= 10'h000;
        end else begin
            off_cnt_ff <= tx_off ? off_cnt_ff + {9'h000, ~&off_cnt_ff} : 10'h000;
        end
    end
    // ==========
    // Properties
    tx_irq_pulse_a: assert property (TX_IRQ |=> !TX_IRQ)
        else $error("tx irq too long");
    rd_idle_zero_a: assert property (!RD |=> RD_DATA == 8'h00)
        else $error("read data not idle");
    ctl0_readback_a: assert property (WR && ADDR == UIC_ADDR_CTL0 ##1 RD && ADDR == UIC_ADDR_CTL0
        |=> RD_DATA == $past(WR_DATA, 2)) else $error("ctl0 readback");
    hold_clear_a: assert property (WR && ADDR == UIC_ADDR_DATA |=> !TX_IRQ [*8])
        else $error("tx irq after load");
    empty_status_a: assert property (WR && ADDR == UIC_ADDR_DATA ##1 RD && ADDR == UIC_ADDR_STATUS
        |=> !RD_DATA[2]) else $error("empty flag not cleared");
    tx_gated_a: assert property (off_cnt_ff > 10'h190 |-> TXD)
        else $error("tx active while gated");
    unmapped_zero_a: assert property (RD && ADDR == 12'h000 |=> RD_DATA == 8'h00)
        else $error("unmapped read");
    rx_err_irq_a: assert property (RD && ADDR == UIC_ADDR_STATUS ##1 RD_DATA[5:3] != 3'h0
        |-> RX_IRQ || $past(RX_IRQ)) else $error("error without rx irq");
    cover property (TX_IRQ);
    cover property ($rose(RX_IRQ));
    cover property (RD && ADDR == UIC_ADDR_DATA);
endmodule : uic_chk
bind uic_top uic_chk i_chk (.*);

// >>> testbench/uic_remote.sv
// Purpose: remote serial device model
// Assumes: 16 clocks per bit
// Notes: nine adds a ninth bit
`timescale 1ns/1ps
module uic_remote (
    input wire logic clk,
    input wire logic txd,
    input wire logic nine,
    output logic rxd,
    output logic cts_n
);
    logic [8:0] got_q[$];
    logic [8:0] sh;
    initial begin
        rxd = 1'b1;
        cts_n = 1'b0;
    end
    // Start, LSB first, optional ninth, stop
    task automatic send(input logic [8:0] d, input logic stp);
        logic [10:0] f;
        f = nine ? {stp, d, 1'b0} : {1'b1, stp, d[7:0], 1'b0};
        for (int i = 0; i < 11; i++) begin
            rxd <= f[i];
            repeat (16) @(posedge clk);
        end
    endtask : send
    always begin
        @(negedge txd);
        repeat (24) @(posedge clk);
        sh = 9'h000;
        for (int i = 0; i < (nine ? 9 : 8); i++) begin
            sh[i] = txd;
            repeat (16) @(posedge clk);
        end
        got_q.push_back(sh);
    end
endmodule : uic_remote

// >>> testbench/uic_top_tb.sv
// Purpose: self-checking bench of the serial control block
// Assumes: baud divisor one, so one bit is 16 clocks
// Notes: frames come from and go to the remote model
`timescale 1ns/1ps
module uic_top_tb;
    import uic_pkg::*;
    logic CLK = 1'b0;
    logic RESET = 1'b1;
    logic WR = 1'b0;
    logic RD = 1'b0;
    logic [11:0] ADDR = 12'h000;
    logic [7:0] WR_DATA = 8'h00;
    logic [7:0] RD_DATA, rv, got;
    logic TXD, TX_IRQ, RX_IRQ, rxd, cts_n;
    logic nine = 1'b0;
    logic [8:0] exp_q[$];
    int err_total = 0;
    int n_tests = 0;
    always #10 CLK = ~CLK;
    uic_top i_dut (.CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WR_DATA(WR_DATA), .WR(WR), .RD(RD),
        .RD_DATA(RD_DATA), .RXD(rxd), .TXD(TXD), .CTS_N(cts_n), .TX_IRQ(TX_IRQ), .RX_IRQ(RX_IRQ));
    uic_remote i_rem (.clk(CLK), .txd(TXD), .nine(nine), .rxd(rxd), .cts_n(cts_n));
    // ==========
    // Tasks
    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] g);
        n_tests++;
        if (g !== e) begin
            err_total++;
            $display("ERROR %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    task automatic bus(input bit w, input bit r, input logic [11:0] wa, input logic [7:0] d, input logic [11:0] ra);
        @(posedge CLK);
        if (w) begin
            WR <= 1'b1;
            ADDR <= wa;
            WR_DATA <= d;
            @(posedge CLK);
            WR <= 1'b0;
        end
        if (r) begin
            RD <= 1'b1;
            ADDR <= ra;
            @(posedge CLK);
            RD <= 1'b0;
            @(posedge CLK);
            got = RD_DATA;
        end
    endtask : bus
    task automatic wr(input logic [11:0] a, input logic [7:0] d);
        bus(1'b1, 1'b0, a, d, a);
    endtask : wr
    task automatic rdc(input string nm, input logic [11:0] a, input logic [7:0] m, input logic [7:0] e);
        bus(1'b0, 1'b1, a, 8'h00, a);
        chk(nm, {1'b0, e}, {1'b0, got & m});
    endtask : rdc
    task automatic wait_irq(input bit tx, input int lim);
        int i;
        for (i = 0; i < lim && (tx ? TX_IRQ : RX_IRQ) !== 1'b1; i++) @(posedge CLK);
        if (i == lim) begin
            chk("irq wait", 9'h001, 9'h000);
            finish_test();
        end
    endtask : wait_irq
    task automatic drain(input int n);
        for (int i = 0; i < 900 && i_rem.got_q.size() < n; i++) @(posedge CLK);
        chk("frame count", 9'(n), 9'(i_rem.got_q.size()));
        if (i_rem.got_q.size() != n) finish_test();
        while (exp_q.size() > 0) chk("tx frame", exp_q.pop_front(), i_rem.got_q.pop_front());
    endtask : drain
    // ==========
    // Main sequence
    initial begin
        rv = 8'($urandom(84));
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        rdc("ctl0 reset", UIC_ADDR_CTL0, 8'hFF, 8'h00);
        rdc("unmapped", 12'h000, 8'hFF, 8'h00);
        rv = 8'($urandom) & 8'h3A;
        bus(1'b1, 1'b1, UIC_ADDR_CTL0, rv, UIC_ADDR_CTL0);
        chk("ctl0", {1'b0, rv}, {1'b0, got});
        $display("registers done");
        for (int p = 0; p < 3; p++) begin
            wr(UIC_ADDR_CTL0, 8'h00);
            nine = p != 0;
            wr(UIC_ADDR_CTL0, 8'(p == 0 ? 8'h80 : 8'h88 + 8'h08 * p));
            for (int k = 0; k < 2; k++) begin
                rv = 8'($urandom);
                exp_q.push_back({p == 0 ? 1'b0 : (^rv) ^ (p == 2), rv});
                bus(1'b1, 1'b1, UIC_ADDR_DATA, rv, UIC_ADDR_STATUS);
                chk("holding empty", 9'h000, {1'b0, got & 8'h04});
                wait_irq(1'b1, 300);
            end
            drain(2);
        end
        wr(UIC_ADDR_CTL0, 8'h00);
        nine = 1'b0;
        i_rem.cts_n <= 1'b1;
        wr(UIC_ADDR_CTL0, 8'hA0);
        rv = 8'($urandom);
        exp_q.push_back({1'b0, rv});
        wr(UIC_ADDR_DATA, rv);
        repeat (450) @(posedge CLK);
        chk("held by cts", 9'h000, 9'(i_rem.got_q.size()));
        i_rem.cts_n <= 1'b0;
        drain(1);
        $display("transmit done");
        wr(UIC_ADDR_CTL0, 8'h00);
        i_rem.send(9'h0A5, 1'b1);
        rdc("rx while off", UIC_ADDR_STATUS, 8'h80, 8'h00);
        wr(UIC_ADDR_CTL0, 8'h40);
        for (int b = 0; b < 3; b++) begin
            rv = 8'($urandom);
            i_rem.send({1'b0, rv}, 1'b1);
            if (b > 0) begin
                i_rem.send(b == 2 ? 9'h000 : 9'h05A, b == 1);
                rdc("held back", UIC_ADDR_STATUS, 8'h28, 8'h00);
            end
            wait_irq(1'b0, 100);
            rdc("rx data", UIC_ADDR_DATA, 8'hFF, rv);
            if (b > 0) begin
                rdc("overrun", UIC_ADDR_STATUS, 8'hA8, b == 2 ? 8'hA8 : 8'hA0);
                bus(1'b0, 1'b1, UIC_ADDR_DATA, 8'h00, UIC_ADDR_DATA);
            end
        end
        wr(UIC_ADDR_CTL0, 8'h00);
        wr(UIC_ADDR_CTL1, 8'h01);
        wr(UIC_ADDR_CTL0, 8'h40);
        i_rem.send(9'h03C, 1'b1);
        repeat (20) @(posedge CLK);
        chk("masked irq", 9'h000, {8'h00, RX_IRQ});
        rdc("masked data", UIC_ADDR_DATA, 8'hFF, 8'h3C);
        i_rem.send(9'h0C3, 1'b0);
        wait_irq(1'b0, 60);
        rdc("framing", UIC_ADDR_STATUS, 8'h90, 8'h90);
        bus(1'b0, 1'b1, UIC_ADDR_DATA, 8'h00, UIC_ADDR_DATA);
        // Multiprocessor filter: a foreign address byte stays silent, a matching one interrupts
        wr(UIC_ADDR_CTL0, 8'h00);
        wr(UIC_ADDR_CTL1, 8'h06);
        wr(UIC_ADDR_MATCH, 8'h5A);
        wr(UIC_ADDR_CTL0, 8'h40);
        nine = 1'b1;
        i_rem.send(9'h133, 1'b1);
        repeat (20) @(posedge CLK);
        chk("mp filtered irq", 9'h000, {8'h00, RX_IRQ});
        rdc("mp other data", UIC_ADDR_DATA, 8'hFF, 8'h33);
        i_rem.send(9'h15A, 1'b1);
        wait_irq(1'b0, 60);
        rdc("mp match data", UIC_ADDR_DATA, 8'hFF, 8'h5A);
        nine = 1'b0;
        $display("receive done");
        wr(UIC_ADDR_CTL0, 8'h00);
        wr(UIC_ADDR_CTL1, 8'h08);
        wait_irq(1'b0, 60);
        rdc("timer flag", UIC_ADDR_STATUS, 8'h02, 8'h02);
        $display("timer done");
        finish_test();
    end
endmodule : uic_top_tb

// >>> verilog/uic_baud_gen.sv
// Purpose: programmable divider giving the oversample or timer tick
// Assumes: divisor zero behaves as one
// Notes: tick pulses once every divisor cycles while run is high
`timescale 1ns/1ps
module uic_baud_gen
    import uic_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    uic_baud_if.gen bif
);
    logic [15:0] cnt_ff;
    logic tick_ff;

    assign bif.tick = tick_ff;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (!bif.run) begin
            cnt_ff <= 16'h0000;
            tick_ff <= 1'b0;
        end else if (cnt_ff <= 16'h0001) begin
            cnt_ff <= bif.divisor;
            tick_ff <= 1'b1;
        end else begin
            cnt_ff <= cnt_ff - 16'h0001;
            tick_ff <= 1'b0;
        end
    end
endmodule : uic_baud_gen

// >>> verilog/uic_baud_if.sv
// Purpose: link between the control logic and the baud divider
// Assumes: one clock domain
// Notes: tick is a one-cycle enable pulse
`timescale 1ns/1ps
interface uic_baud_if;
    logic run;
    logic [15:0] divisor;
    logic tick;
    modport gen (input run, input divisor, output tick);
    modport user (output run, output divisor, input tick);
endinterface : uic_baud_if

// >>> verilog/uic_pkg.sv
// Purpose: constants, register map and state types of the serial port control block
// Assumes: byte-wide register port, 12-bit addresses, 16x oversampling of each bit
package uic_pkg;
    // ==========================================================
    // Register map
    localparam logic [11:0] UIC_ADDR_DATA = 12'hF40;
    localparam logic [11:0] UIC_ADDR_STATUS = 12'hF41;
    localparam logic [11:0] UIC_ADDR_CTL0 = 12'hF42;
    localparam logic [11:0] UIC_ADDR_CTL1 = 12'hF43;
    localparam logic [11:0] UIC_ADDR_MATCH = 12'hF44;
    localparam logic [11:0] UIC_ADDR_BAUD_HI = 12'hF46;
    localparam logic [11:0] UIC_ADDR_BAUD_LO = 12'hF47;
    // ==========================================================
    // Control register zero fields
    localparam int UIC_C0_TX_ENABLE = 7;
    localparam int UIC_C0_RX_ENABLE = 6;
    localparam int UIC_C0_FLOW_CONTROL_ENABLE = 5;
    localparam int UIC_C0_PARITY_ENABLE = 4;
    localparam int UIC_C0_PARITY_ODD = 3;
    localparam int UIC_C0_SEND_BREAK = 2;
    localparam int UIC_C0_TWO_STOP = 1;
    localparam int UIC_C0_LOOPBACK_ENABLE = 0;
    // ==========================================================
    // Control register one fields
    localparam int UIC_C1_RX_DATA_IRQ_DIS = 0;
    localparam int UIC_C1_MULTIPROC_MODE_ENABLE = 1;
    localparam int UIC_C1_MP_FILTER = 2;
    localparam int UIC_C1_TIMER_IRQ_EN = 3;
    localparam int UIC_C1_TX_ADDR_BIT = 4;
    // ==========================================================
    // Reset values and timing
    localparam logic [7:0] UIC_CTL0_RESET = 8'h00;
    localparam logic [7:0] UIC_CTL1_RESET = 8'h00;
    localparam logic [7:0] UIC_MATCH_RESET = 8'h00;
    localparam logic [15:0] UIC_BAUD_RESET = 16'h0001;
    localparam logic [3:0] UIC_BIT_LAST_TICK = 4'hF;
    localparam logic [3:0] UIC_START_MID_TICK = 4'h7;
    localparam logic [2:0] UIC_LAST_DATA_BIT = 3'h7;
    // ==========================================================
    // State types
    typedef enum logic [4:0] {
        UIC_TX_IDLE = 5'h01,
        UIC_TX_START = 5'h02,
        UIC_TX_DATA = 5'h04,
        UIC_TX_NINTH = 5'h08,
        UIC_TX_STOP = 5'h10
    } uic_tx_state_type;
    typedef enum logic [4:0] {
        UIC_RX_IDLE = 5'h01,
        UIC_RX_START = 5'h02,
        UIC_RX_DATA = 5'h04,
        UIC_RX_NINTH = 5'h08,
        UIC_RX_STOP = 5'h10
    } uic_rx_state_type;
endpackage : uic_pkg

// >>> verilog/uic_top.sv
// Purpose: serial port with transmit/receive enables, overrun handling and interrupts
// Assumes: register strobes one cycle long; CTS_N and RXD asynchronous
// Notes: data register reads and status reads have side effects
`timescale 1ns/1ps
module uic_top
    import uic_pkg::*;
(
    input wire logic CLK,
    input wire logic RESET,
    input wire logic [11:0] ADDR,
    input wire logic [7:0] WR_DATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RD_DATA,
    input wire logic RXD,
    output logic TXD,
    input wire logic CTS_N,
    output logic TX_IRQ,
    output logic RX_IRQ
);
    // ==========================================================
    // Registers and decode
    logic [7:0] ctl0_ff;
    logic [7:0] ctl1_ff;
    logic [7:0] match_ff;
    logic [15:0] baud_ff;
    logic [7:0] rd_data_ff;
    logic wr_data;
    logic rd_data_acc;
    logic rd_status;
    logic cts_s1_ff;
    logic cts_s2_ff;
    logic rxd_s1_ff;
    logic rxd_s2_ff;
    logic tx_en_eff;
    logic rx_en;
    logic mp_en;
    logic nine_bit;
    logic primary_off;

    assign wr_data = WR && (ADDR == UIC_ADDR_DATA);
    assign rd_data_acc = RD && (ADDR == UIC_ADDR_DATA);
    assign rd_status = RD && (ADDR == UIC_ADDR_STATUS);
    assign mp_en = ctl1_ff[UIC_C1_MULTIPROC_MODE_ENABLE];
    assign nine_bit = mp_en | ctl0_ff[UIC_C0_PARITY_ENABLE];
    assign tx_en_eff = ctl0_ff[UIC_C0_TX_ENABLE] & (~ctl0_ff[UIC_C0_FLOW_CONTROL_ENABLE] | ~cts_s2_ff);
    assign rx_en = ctl0_ff[UIC_C0_RX_ENABLE];
    assign primary_off = ~ctl0_ff[UIC_C0_TX_ENABLE] & ~ctl0_ff[UIC_C0_RX_ENABLE];

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            ctl0_ff <= UIC_CTL0_RESET;
            ctl1_ff <= UIC_CTL1_RESET;
            match_ff <= UIC_MATCH_RESET;
            baud_ff <= UIC_BAUD_RESET;
        end else if (WR) begin
            case (ADDR)
                UIC_ADDR_CTL0: ctl0_ff <= WR_DATA;
                UIC_ADDR_CTL1: ctl1_ff <= WR_DATA;
                UIC_ADDR_MATCH: match_ff <= WR_DATA;
                UIC_ADDR_BAUD_HI: baud_ff[15:8] <= WR_DATA;
                UIC_ADDR_BAUD_LO: baud_ff[7:0] <= WR_DATA;
                default: ;
            endcase
        end
    end

    // Pin synchronisers
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            cts_s1_ff <= 1'b1;
            cts_s2_ff <= 1'b1;
            rxd_s1_ff <= 1'b1;
            rxd_s2_ff <= 1'b1;
        end else begin
            cts_s1_ff <= CTS_N;
            cts_s2_ff <= cts_s1_ff;
            rxd_s1_ff <= RXD;
            rxd_s2_ff <= rxd_s1_ff;
        end
    end

    // ==========================================================
    // Baud divider
    uic_baud_if bif ();
    logic tick;

    assign bif.run = ~primary_off | ctl1_ff[UIC_C1_TIMER_IRQ_EN];
    assign bif.divisor = baud_ff;
    assign tick = bif.tick;

    uic_baud_gen u_baud (
        .CLK(CLK),
        .RESET(RESET),
        .bif(bif)
    );

    // ==========================================================
    // Transmitter
    uic_tx_state_type tx_state_ff;
    logic [3:0] tx_tick_ff;
    logic [2:0] tx_bit_ff;
    logic [7:0] tx_shift_ff;
    logic [7:0] tx_hold_ff;
    logic tx_full_ff;
    logic tx_empty_ff;
    logic tx_ninth_ff;
    logic tx_stop2_ff;
    logic txd_ff;
    logic tx_irq_ff;
    logic tx_bit_end;
    logic tx_load;
    logic tx_first_done;
    logic tx_line;

    assign tx_bit_end = tick && (tx_tick_ff == UIC_BIT_LAST_TICK);
    assign tx_load = tx_full_ff && tx_en_eff && tick;
    assign tx_first_done = (tx_state_ff == UIC_TX_DATA) && tx_bit_end && (tx_bit_ff == 3'h0);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tx_state_ff <= UIC_TX_IDLE;
            tx_tick_ff <= 4'h0;
            tx_bit_ff <= 3'h0;
            tx_shift_ff <= 8'h00;
            tx_ninth_ff <= 1'b0;
            tx_stop2_ff <= 1'b0;
        end else begin
            if (tick && (tx_state_ff != UIC_TX_IDLE)) begin
                tx_tick_ff <= tx_tick_ff + 4'h1;
            end
            case (tx_state_ff)
                UIC_TX_IDLE: begin
                    if (tx_load) begin
                        tx_state_ff <= UIC_TX_START;
                        tx_tick_ff <= 4'h0;
                        tx_shift_ff <= tx_hold_ff;
                        tx_ninth_ff <= mp_en ? ctl1_ff[UIC_C1_TX_ADDR_BIT] : (^tx_hold_ff) ^ ctl0_ff[UIC_C0_PARITY_ODD];
                    end
                end
                UIC_TX_START: begin
                    if (tx_bit_end) begin
                        tx_state_ff <= UIC_TX_DATA;
                        tx_bit_ff <= 3'h0;
                    end
                end
                UIC_TX_DATA: begin
                    if (tx_bit_end) begin
                        tx_shift_ff <= {1'b1, tx_shift_ff[7:1]};
                        tx_bit_ff <= tx_bit_ff + 3'h1;
                        if (tx_bit_ff == UIC_LAST_DATA_BIT) begin
                            tx_state_ff <= nine_bit ? UIC_TX_NINTH : UIC_TX_STOP;
                            tx_stop2_ff <= 1'b0;
                        end
                    end
                end
                UIC_TX_NINTH: begin
                    if (tx_bit_end) begin
                        tx_state_ff <= UIC_TX_STOP;
                        tx_stop2_ff <= 1'b0;
                    end
                end
                UIC_TX_STOP: begin
                    if (tx_bit_end) begin
                        if (ctl0_ff[UIC_C0_TWO_STOP] && !tx_stop2_ff) begin
                            tx_stop2_ff <= 1'b1;
                        end else if (tx_load) begin
                            // Next character follows with no idle gap
                            tx_state_ff <= UIC_TX_START;
                            tx_tick_ff <= 4'h0;
                            tx_shift_ff <= tx_hold_ff;
                            tx_ninth_ff <= mp_en ? ctl1_ff[UIC_C1_TX_ADDR_BIT] : (^tx_hold_ff) ^ ctl0_ff[UIC_C0_PARITY_ODD];
                        end else begin
                            tx_state_ff <= UIC_TX_IDLE;
                        end
                    end
                end
                default: tx_state_ff <= UIC_TX_IDLE;
            endcase
        end
    end

    // Holding register and empty flag
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            tx_hold_ff <= 8'h00;
            tx_full_ff <= 1'b0;
            tx_empty_ff <= 1'b1;
            tx_irq_ff <= 1'b0;
        end else begin
            tx_irq_ff <= tx_first_done && !tx_empty_ff;
            if (wr_data) begin
                tx_hold_ff <= WR_DATA;
                tx_full_ff <= 1'b1;
                tx_empty_ff <= 1'b0;
            end else if (tx_load && ((tx_state_ff == UIC_TX_IDLE) || (tx_state_ff == UIC_TX_STOP && tx_bit_end
                         && !(ctl0_ff[UIC_C0_TWO_STOP] && !tx_stop2_ff)))) begin
                tx_full_ff <= 1'b0;
            end
            if (tx_first_done) begin
                tx_empty_ff <= 1'b1;
            end
        end
    end

    always_comb begin
        case (tx_state_ff)
            UIC_TX_START: tx_line = 1'b0;
            UIC_TX_DATA: tx_line = tx_shift_ff[0];
            UIC_TX_NINTH: tx_line = tx_ninth_ff;
            default: tx_line = 1'b1;
        endcase
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            txd_ff <= 1'b1;
        end else begin
            txd_ff <= tx_line & ~ctl0_ff[UIC_C0_SEND_BREAK];
        end
    end

    // ==========================================================
    // Receiver
    uic_rx_state_type rx_state_ff;
    logic [3:0] rx_tick_ff;
    logic [2:0] rx_bit_ff;
    logic [7:0] rx_shift_ff;
    logic rx_ninth_ff;
    logic rx_done_ff;
    logic rx_fe_ff;
    logic rx_brk_ff;
    logic rx_line;
    logic rx_sample;

    assign rx_line = ctl0_ff[UIC_C0_LOOPBACK_ENABLE] ? txd_ff : rxd_s2_ff;
    assign rx_sample = tick && (rx_tick_ff == UIC_BIT_LAST_TICK);

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rx_state_ff <= UIC_RX_IDLE;
            rx_tick_ff <= 4'h0;
            rx_bit_ff <= 3'h0;
            rx_shift_ff <= 8'h00;
            rx_ninth_ff <= 1'b0;
            rx_done_ff <= 1'b0;
            rx_fe_ff <= 1'b0;
            rx_brk_ff <= 1'b0;
        end else begin
            rx_done_ff <= 1'b0;
            if (tick) begin
                rx_tick_ff <= rx_tick_ff + 4'h1;
            end
            case (rx_state_ff)
                UIC_RX_IDLE: begin
                    rx_tick_ff <= 4'h0;
                    if (rx_en && !rx_line) begin
                        rx_state_ff <= UIC_RX_START;
                    end
                end
                UIC_RX_START: begin
                    if (tick && (rx_tick_ff == UIC_START_MID_TICK)) begin
                        rx_tick_ff <= 4'h0;
                        rx_bit_ff <= 3'h0;
                        rx_state_ff <= rx_line ? UIC_RX_IDLE : UIC_RX_DATA;
                    end
                end
                UIC_RX_DATA: begin
                    if (rx_sample) begin
                        rx_shift_ff <= {rx_line, rx_shift_ff[7:1]};
                        rx_bit_ff <= rx_bit_ff + 3'h1;
                        if (rx_bit_ff == UIC_LAST_DATA_BIT) begin
                            rx_ninth_ff <= 1'b0;
                            rx_state_ff <= nine_bit ? UIC_RX_NINTH : UIC_RX_STOP;
                        end
                    end
                end
                UIC_RX_NINTH: begin
                    if (rx_sample) begin
                        rx_ninth_ff <= rx_line;
                        rx_state_ff <= UIC_RX_STOP;
                    end
                end
                UIC_RX_STOP: begin
                    if (rx_sample) begin
                        rx_done_ff <= 1'b1;
                        rx_fe_ff <= ~rx_line;
                        rx_brk_ff <= ~rx_line && (rx_shift_ff == 8'h00) && !rx_ninth_ff;
                        rx_state_ff <= UIC_RX_IDLE;
                    end
                end
                default: rx_state_ff <= UIC_RX_IDLE;
            endcase
            if (!rx_en) begin
                rx_state_ff <= UIC_RX_IDLE;
            end
        end
    end

    // ==========================================================
    // Receive status, overrun and interrupts
    logic [7:0] rx_hold_ff;
    logic rda_ff;
    logic rx_int_ok_ff;
    logic addressed_ff;
    logic ovr_ff;
    logic ovr_pend_ff;
    logic brk_ff;
    logic brk_pend_ff;
    logic fe_ff;
    logic pe_ff;
    logic timer_ff;
    logic rx_irq_ff;
    logic rx_overrun;
    logic rx_pe;
    logic rx_is_addr;
    logic rx_match;

    assign rx_overrun = rx_done_ff && rda_ff && !rd_data_acc;
    assign rx_pe = ctl0_ff[UIC_C0_PARITY_ENABLE] && !mp_en && ((^rx_shift_ff) ^ rx_ninth_ff ^ ctl0_ff[UIC_C0_PARITY_ODD]);
    assign rx_is_addr = mp_en && rx_ninth_ff;
    assign rx_match = rx_shift_ff == match_ff;

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rx_hold_ff <= 8'h00;
            rda_ff <= 1'b0;
            rx_int_ok_ff <= 1'b0;
            addressed_ff <= 1'b0;
            ovr_ff <= 1'b0;
            ovr_pend_ff <= 1'b0;
            brk_ff <= 1'b0;
            brk_pend_ff <= 1'b0;
            fe_ff <= 1'b0;
            pe_ff <= 1'b0;
        end else begin
            if (rd_status) begin
                ovr_ff <= 1'b0;
                brk_ff <= 1'b0;
                fe_ff <= 1'b0;
                pe_ff <= 1'b0;
            end
            if (rd_data_acc) begin
                rda_ff <= 1'b0;
                if (ovr_pend_ff) begin
                    ovr_ff <= 1'b1;
                    brk_ff <= brk_pend_ff;
                    rda_ff <= 1'b1;
                    ovr_pend_ff <= 1'b0;
                end
            end
            if (rx_overrun) begin
                ovr_pend_ff <= 1'b1;
                brk_pend_ff <= rx_brk_ff;
            end else if (rx_done_ff) begin
                rx_hold_ff <= rx_shift_ff;
                rda_ff <= 1'b1;
                fe_ff <= rx_fe_ff;
                brk_ff <= rx_brk_ff;
                pe_ff <= rx_pe;
                if (rx_is_addr) begin
                    addressed_ff <= rx_match;
                end
                rx_int_ok_ff <= !mp_en || !ctl1_ff[UIC_C1_MP_FILTER] || (rx_is_addr ? rx_match : addressed_ff);
            end
        end
    end

    // Timer event while the port's main function is off
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            timer_ff <= 1'b0;
        end else if (tick && primary_off && ctl1_ff[UIC_C1_TIMER_IRQ_EN]) begin
            timer_ff <= 1'b1;
        end else if (rd_status) begin
            timer_ff <= 1'b0;
        end
    end

    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rx_irq_ff <= 1'b0;
        end else begin
            rx_irq_ff <= (rda_ff && rx_int_ok_ff && !ctl1_ff[UIC_C1_RX_DATA_IRQ_DIS])
                         || brk_ff || ovr_ff || fe_ff
                         || (timer_ff && ctl1_ff[UIC_C1_TIMER_IRQ_EN]);
        end
    end

    // ==========================================================
    // Read data, valid only in the cycle after the read strobe
    always_ff @(posedge CLK or posedge RESET) begin
        if (RESET) begin
            rd_data_ff <= 8'h00;
        end else if (RD) begin
            case (ADDR)
                UIC_ADDR_DATA: rd_data_ff <= rx_hold_ff;
                UIC_ADDR_STATUS: rd_data_ff <= {rda_ff, pe_ff, ovr_ff, fe_ff, brk_ff, tx_empty_ff, timer_ff, cts_s2_ff};
                UIC_ADDR_CTL0: rd_data_ff <= ctl0_ff;
                UIC_ADDR_CTL1: rd_data_ff <= ctl1_ff;
                UIC_ADDR_MATCH: rd_data_ff <= match_ff;
                UIC_ADDR_BAUD_HI: rd_data_ff <= baud_ff[15:8];
                UIC_ADDR_BAUD_LO: rd_data_ff <= baud_ff[7:0];
                default: rd_data_ff <= 8'h00;
            endcase
        end else begin
            rd_data_ff <= 8'h00;
        end
    end

    assign RD_DATA = rd_data_ff;
    assign TXD = txd_ff;
    assign TX_IRQ = tx_irq_ff;
    assign RX_IRQ = rx_irq_ff;
endmodule : uic_top
